// ### shared/cid_pkg.sv
// constants, state codes and carrier structs of the cpu interrupt dispatch block
// assumes a single cpu clock and an apb register port of 32-bit words
package cid_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS_FLAGS_REGISTER = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0c;
  localparam logic [7:0] OFS_SP = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;
  // field positions and reset values
  localparam int unsigned GIE_BIT = 7;
  localparam int unsigned VSEL_BIT = 0;
  localparam logic [7:0] STATUS_FLAGS_REGISTER_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] RET_ADDR_BYTES = 16'h0002;
  localparam logic [15:0] ONE_BYTE = 16'h0001;
  // cycle figures
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] ENTRY_CYCLES = 4'h4;
  localparam logic [CNT_W-1:0] SLEEP_EXTRA_CYCLES = 4'h4;
  localparam logic [CNT_W-1:0] RETURN_CYCLES = 4'h4;
  localparam logic [CNT_W-1:0] JUMP_CYCLES = 4'h3;
  // sequence steps inside entry and return
  localparam logic [CNT_W-1:0] STEP_PUSH_LOW = 4'h0;
  localparam logic [CNT_W-1:0] STEP_PUSH_HIGH = 4'h1;
  localparam logic [CNT_W-1:0] STEP_POP_HIGH = 4'h0;
  localparam logic [CNT_W-1:0] STEP_POP_LOW = 4'h1;
  localparam logic [CNT_W-1:0] STEP_CATCH_HIGH = 4'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ENTRY = 2'b01,
    ST_RETURN = 2'b10
  } cid_state_t;

  typedef struct packed {
    logic instr_boundary;
    logic cli_exec;
    logic sei_exec;
    logic return_from_handler_instr_exec;
    logic asleep;
  } cid_cpu_evt_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cid_stack_t;
endpackage : cid_pkg

// ### rtl/cid_flags.sv
// pending state of the interrupt sources: sticky flags or live levels
// assumes event inputs are one-cycle pulses synchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module cid_flags #(
  parameter int unsigned NSRC = 8,
  parameter logic [NSRC-1:0] LEVEL_MASK = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NSRC-1:0] set_evt,
  input wire logic [NSRC-1:0] level_in,
  input wire logic [NSRC-1:0] sw_clear,
  input wire logic [NSRC-1:0] hw_ack,
  output logic [NSRC-1:0] pending
);
  logic [NSRC-1:0] flag_q;
  wire [NSRC-1:0] flag_set = set_evt & ~LEVEL_MASK;
  wire [NSRC-1:0] flag_clr = sw_clear | hw_ack;
  // a new event beats a clear in the same cycle
  wire [NSRC-1:0] next_flag = (flag_q & ~flag_clr) | flag_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= next_flag;
    end
  end

  // level sources carry no flag and vanish with their condition
  assign pending = (flag_q & ~LEVEL_MASK) | (level_in & LEVEL_MASK);

  wire [NSRC-1:0] clr_only = flag_clr & ~flag_set;

  property p_flag_kept;
    @(posedge pclk) disable iff (!presetn)
      (|flag_set) |=> ((flag_q & $past(flag_set)) == $past(flag_set));
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("event flag not set");

  property p_flag_cleared;
    @(posedge pclk) disable iff (!presetn)
      (|clr_only) |=> ((flag_q & $past(clr_only)) == '0);
  endproperty
  a_flag_cleared: assert property (p_flag_cleared) else $error("flag not cleared");

  property p_level_no_flag;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |-> ((flag_q & LEVEL_MASK) == '0);
  endproperty
  a_level_no_flag: assert property (p_level_no_flag) else $error("level source has a flag");
endmodule : cid_flags
`default_nettype wire

// ### rtl/cid_prio.sv
// fixed priority pick: the lowest index, which owns the lowest vector, wins
// assumes index 0 is external request zero
`timescale 1ns/100ps
`default_nettype none
module cid_prio #(
  parameter int unsigned NSRC = 8,
  parameter int unsigned IDX_W = 3
) (
  input wire logic [NSRC-1:0] req,
  output logic valid,
  output logic [IDX_W-1:0] idx,
  output logic [NSRC-1:0] onehot
);
  function automatic logic [IDX_W-1:0] cid_lowest(input logic [NSRC-1:0] r);
    logic [IDX_W-1:0] k;
    k = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (r[i]) begin
        k = IDX_W'(i);
      end
    end
    return k;
  endfunction : cid_lowest

  assign valid = |req;
  assign idx = cid_lowest(req);
  assign onehot = valid ? (NSRC'(1) << idx) : '0;

  property p_lowest_wins;
    @(req) valid |-> (((onehot - NSRC'(1)) & req) == '0) && ((onehot & req) != '0);
  endproperty
  a_lowest_wins: assert property (p_lowest_wins) else $error("priority pick wrong");
endmodule : cid_prio
`default_nettype wire

// ### rtl/cid_dispatch.sv
// reset and interrupt dispatch for an 8-bit cpu core, registers on apb
// assumes the pipeline marks each completed instruction and holds while cpu_hold is high
`timescale 1ns/100ps
`default_nettype none
module cid_dispatch #(
  parameter int unsigned NSRC = 8,
  parameter int unsigned PC_W = 13,
  parameter int unsigned BOOT_START = 32'h0000_1c00,
  parameter int unsigned VEC_STEP = 2,
  parameter logic [NSRC-1:0] LEVEL_MASK = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NSRC-1:0] src_event,
  input wire logic [NSRC-1:0] src_level,
  input wire cid_pkg::cid_cpu_evt_t cpu_evt,
  input wire logic [PC_W-1:0] cur_pc,
  input wire logic app_section_lock_bit,
  input wire logic boot_section_lock_bit,
  input wire logic boot_reset_fuse,
  output logic cpu_hold,
  output var cid_pkg::cid_stack_t stack_bus,
  input wire logic [7:0] stack_rdata,
  output logic pc_load,
  output logic [PC_W-1:0] pc_load_value,
  output logic [PC_W-1:0] reset_vector,
  output logic [NSRC-1:0] src_ack
);
  localparam int unsigned IDX_W = (NSRC > 1) ? $clog2(NSRC) : 1;
  localparam logic [PC_W-1:0] BOOT_BASE = PC_W'(BOOT_START);
  localparam logic [PC_W-1:0] LOW_BASE = '0;
  localparam int unsigned CW = cid_pkg::CNT_W;

  generate
    if (NSRC < 1 || NSRC > 31) begin : g_bad_nsrc
      $error("NSRC must lie in 1..31");
    end
    if (PC_W < 9 || PC_W > 16) begin : g_bad_pcw
      $error("PC_W must lie in 9..16");
    end
    if (VEC_STEP < 1 || BOOT_START >= (32'h1 << PC_W)) begin : g_bad_vec
      $error("vector step or boot start out of range");
    end
  endgenerate

  // software visible state
  logic [7:0] status_flags_register;
  logic vector_relocate_select;
  logic [NSRC-1:0] src_enable;
  logic [15:0] stack_ptr;
  logic [CW-1:0] last_latency;

  // sequencer state
  cid_pkg::cid_state_t state;
  cid_pkg::cid_state_t next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] entry_len;
  logic [15:0] ret_pc;
  logic [PC_W-1:0] vector_q;
  logic [7:0] pop_high;
  logic pslverr_q;

  // apb decode
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite;
  wire hit_status_flags_register = paddr == cid_pkg::OFS_STATUS_FLAGS_REGISTER;
  wire hit_ctrl = paddr == cid_pkg::OFS_CTRL;
  wire hit_enable = paddr == cid_pkg::OFS_ENABLE;
  wire hit_flags = paddr == cid_pkg::OFS_FLAGS;
  wire hit_sp = paddr == cid_pkg::OFS_SP;
  wire hit_state = paddr == cid_pkg::OFS_STATE;
  wire mapped = hit_status_flags_register | hit_ctrl | hit_enable | hit_flags | hit_sp | hit_state;
  wire wr_status_flags_register = apb_wr & hit_status_flags_register;
  wire wr_ctrl = apb_wr & hit_ctrl;
  wire wr_enable = apb_wr & hit_enable;
  wire wr_flags = apb_wr & hit_flags;
  wire wr_sp = apb_wr & hit_sp;

  // pending sources and the priority pick
  wire [NSRC-1:0] pending;
  wire [NSRC-1:0] sw_clear = wr_flags ? pwdata[NSRC-1:0] : '0;
  wire [NSRC-1:0] armed = pending & src_enable;
  wire win_valid;
  wire [IDX_W-1:0] win_idx;
  wire [NSRC-1:0] win_onehot;

  cid_flags #(
    .NSRC(NSRC),
    .LEVEL_MASK(LEVEL_MASK)
  ) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_evt(src_event),
    .level_in(src_level),
    .sw_clear(sw_clear),
    .hw_ack(src_ack),
    .pending(pending)
  );

  cid_prio #(
    .NSRC(NSRC),
    .IDX_W(IDX_W)
  ) u_prio (
    .req(armed),
    .valid(win_valid),
    .idx(win_idx),
    .onehot(win_onehot)
  );

  wire gie = status_flags_register[cid_pkg::GIE_BIT];
  wire in_boot = cur_pc >= BOOT_BASE;
  // each lock bit guards the section that it protects
  wire lock_block = (app_section_lock_bit & ~in_boot) | (boot_section_lock_bit & in_boot);
  wire idle = state == cid_pkg::ST_IDLE;

  // requests are only looked at when an instruction has fully completed;
  // a cli, sei or return_from_handler_instr finishing in this cycle keeps the door shut
  wire take = idle & cpu_evt.instr_boundary & ~cpu_evt.cli_exec & ~cpu_evt.sei_exec
    & ~cpu_evt.return_from_handler_instr_exec & gie & win_valid & ~lock_block;
  wire ret_go = idle & cpu_evt.return_from_handler_instr_exec;
  assign src_ack = take ? win_onehot : '0;

  // vector placement: reset at the base, source i at base + (i+1) * step
  wire [PC_W-1:0] vec_base = vector_relocate_select ? BOOT_BASE : LOW_BASE;
  wire [PC_W-1:0] vec_calc = vec_base + PC_W'((32'(win_idx) + 1) * VEC_STEP);

  wire [CW-1:0] sleep_len = cid_pkg::ENTRY_CYCLES + cid_pkg::SLEEP_EXTRA_CYCLES;
  wire [CW-1:0] take_len = cpu_evt.asleep ? sleep_len : cid_pkg::ENTRY_CYCLES;
  wire [CW-1:0] seq_len = (state == cid_pkg::ST_RETURN) ? cid_pkg::RETURN_CYCLES : entry_len;
  wire seq_last = cnt == (seq_len - CW'(1));
  wire entry_last = (state == cid_pkg::ST_ENTRY) & seq_last;
  wire ret_last = (state == cid_pkg::ST_RETURN) & seq_last;

  always_comb begin
    next_state = state;
    case (state)
      cid_pkg::ST_IDLE: begin
        if (take) begin
          next_state = cid_pkg::ST_ENTRY;
        end else if (ret_go) begin
          next_state = cid_pkg::ST_RETURN;
        end
      end
      cid_pkg::ST_ENTRY: begin
        if (seq_last) begin
          next_state = cid_pkg::ST_IDLE;
        end
      end
      cid_pkg::ST_RETURN: begin
        if (seq_last) begin
          next_state = cid_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = cid_pkg::ST_IDLE;
      end
    endcase
  end

  // stack traffic: low byte at sp, high byte at sp-1; pops mirror it
  wire push_low = (state == cid_pkg::ST_ENTRY) & (cnt == cid_pkg::STEP_PUSH_LOW);
  wire push_high = (state == cid_pkg::ST_ENTRY) & (cnt == cid_pkg::STEP_PUSH_HIGH);
  wire pop_hi_req = (state == cid_pkg::ST_RETURN) & (cnt == cid_pkg::STEP_POP_HIGH);
  wire pop_lo_req = (state == cid_pkg::ST_RETURN) & (cnt == cid_pkg::STEP_POP_LOW);
  wire catch_high = (state == cid_pkg::ST_RETURN) & (cnt == cid_pkg::STEP_CATCH_HIGH);
  cid_pkg::cid_stack_t next_stack;
  always_comb begin
    next_stack = '0;
    next_stack.req = push_low | push_high | pop_hi_req | pop_lo_req;
    next_stack.we = push_low | push_high;
    if (push_low) begin
      next_stack.addr = stack_ptr;
      next_stack.wdata = ret_pc[7:0];
    end else if (push_high) begin
      next_stack.addr = stack_ptr - cid_pkg::ONE_BYTE;
      next_stack.wdata = ret_pc[15:8];
    end else if (pop_hi_req) begin
      next_stack.addr = stack_ptr + cid_pkg::ONE_BYTE;
    end else if (pop_lo_req) begin
      next_stack.addr = stack_ptr + cid_pkg::RET_ADDR_BYTES;
    end
  end

  wire [15:0] popped_pc = {pop_high, stack_rdata};
  wire [PC_W-1:0] next_pc_value = entry_last ? vector_q : popped_pc[PC_W-1:0];

  // global enable: entry clears, return sets, then cli and sei, then software;
  // the other status bits are never touched by entry or return
  wire [7:0] status_flags_register_sw = wr_status_flags_register ? pwdata[7:0] : status_flags_register;
  wire gie_after_sw = cpu_evt.cli_exec ? 1'b0 : (cpu_evt.sei_exec ? 1'b1 : status_flags_register_sw[cid_pkg::GIE_BIT]);
  wire next_gie = take ? 1'b0 : (ret_last ? 1'b1 : gie_after_sw);
  wire [7:0] gie_mask = 8'h01 << cid_pkg::GIE_BIT;
  wire [7:0] next_status_flags_register = (status_flags_register_sw & ~gie_mask) | (next_gie ? gie_mask : 8'h00);

  // hardware stack moves win over a software write in the same cycle
  wire [15:0] next_sp = entry_last ? stack_ptr - cid_pkg::RET_ADDR_BYTES
    : ret_last ? stack_ptr + cid_pkg::RET_ADDR_BYTES
    : wr_sp ? pwdata[15:0] : stack_ptr;

  wire [31:0] rd_state = {16'h0000, 4'h0, last_latency, 5'h00, ~idle, 2'(state)};
  wire [31:0] rd_mux = hit_status_flags_register ? {24'h000000, status_flags_register}
    : hit_ctrl ? {31'h00000000, vector_relocate_select}
    : hit_enable ? 32'(src_enable)
    : hit_flags ? 32'(pending)
    : hit_sp ? {16'h0000, stack_ptr}
    : hit_state ? rd_state : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cid_pkg::ST_IDLE;
      cnt <= '0;
      entry_len <= cid_pkg::ENTRY_CYCLES;
      vector_q <= '0;
      ret_pc <= '0;
      last_latency <= '0;
    end else begin
      state <= next_state;
      cnt <= (next_state != state) ? '0 : cnt + CW'(1);
      if (take) begin
        entry_len <= take_len;
        vector_q <= vec_calc;
        ret_pc <= 16'(cur_pc);
        // the vector jump itself runs in the pipeline after the hold drops
        last_latency <= take_len + cid_pkg::JUMP_CYCLES;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_bus <= '0;
      pop_high <= 8'h00;
      pc_load <= 1'b0;
      pc_load_value <= '0;
    end else begin
      stack_bus <= next_stack;
      pop_high <= catch_high ? stack_rdata : pop_high;
      pc_load <= entry_last | ret_last;
      pc_load_value <= (entry_last | ret_last) ? next_pc_value : pc_load_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_flags_register <= cid_pkg::STATUS_FLAGS_REGISTER_RESET;
      vector_relocate_select <= 1'b0;
      src_enable <= '0;
      stack_ptr <= cid_pkg::SP_RESET;
    end else begin
      status_flags_register <= next_status_flags_register;
      vector_relocate_select <= wr_ctrl ? pwdata[cid_pkg::VSEL_BIT] : vector_relocate_select;
      src_enable <= wr_enable ? pwdata[NSRC-1:0] : src_enable;
      stack_ptr <= next_sp;
    end
  end

  // read data and error are fixed in the setup cycle, so the access ends at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr_q <= 1'b0;
      reset_vector <= '0;
    end else begin
      prdata <= apb_setup ? rd_mux : prdata;
      pslverr_q <= apb_setup ? ~mapped : pslverr_q;
      reset_vector <= boot_reset_fuse ? BOOT_BASE : LOW_BASE;
    end
  end

  assign pready = 1'b1;
  assign pslverr = pslverr_q & psel & penable;
  assign cpu_hold = ~idle;

  property p_take_needs_enables;
    @(posedge pclk) disable iff (!presetn)
      take |-> gie && ((src_enable & src_ack) == src_ack) && !lock_block;
  endproperty
  a_take_needs_enables: assert property (p_take_needs_enables) else $error("take while disabled");

  property p_take_clears_gie;
    @(posedge pclk) disable iff (!presetn)
      take |=> !gie;
  endproperty
  a_take_clears_gie: assert property (p_take_clears_gie) else $error("enable kept on entry");

  property p_entry_time;
    @(posedge pclk) disable iff (!presetn)
      take && !cpu_evt.asleep |=> (cpu_hold && !pc_load)[*4] ##1 (pc_load && !cpu_hold);
  endproperty
  a_entry_time: assert property (p_entry_time) else $error("entry length wrong");

  property p_sleep_entry_time;
    @(posedge pclk) disable iff (!presetn)
      take && cpu_evt.asleep |=> (cpu_hold && !pc_load)[*8] ##1 pc_load;
  endproperty
  a_sleep_entry_time: assert property (p_sleep_entry_time) else $error("wake entry wrong");

  property p_entry_sp;
    @(posedge pclk) disable iff (!presetn)
      entry_last |=> stack_ptr == $past(stack_ptr) - cid_pkg::RET_ADDR_BYTES;
  endproperty
  a_entry_sp: assert property (p_entry_sp) else $error("stack not lowered by two");

  property p_return_time;
    @(posedge pclk) disable iff (!presetn)
      ret_go |=> (cpu_hold && !pc_load)[*4] ##1 (pc_load && gie && !cpu_hold);
  endproperty
  a_return_time: assert property (p_return_time) else $error("return sequence wrong");

  property p_cli_now;
    @(posedge pclk) disable iff (!presetn)
      cpu_evt.cli_exec |-> !take ##1 !gie;
  endproperty
  a_cli_now: assert property (p_cli_now) else $error("take after cli");

  property p_vector_loaded;
    @(posedge pclk) disable iff (!presetn)
      entry_last |=> pc_load && (pc_load_value == $past(vector_q)) && (vector_q != LOW_BASE);
  endproperty
  a_vector_loaded: assert property (p_vector_loaded) else $error("bad vector");

  property p_one_source;
    @(posedge pclk) disable iff (!presetn)
      take |-> $onehot(src_ack) ##1 (state == cid_pkg::ST_ENTRY);
  endproperty
  a_one_source: assert property (p_one_source) else $error("dispatch not single");
endmodule : cid_dispatch
`default_nettype wire

// ### testbench/cid_stack_model.sv
// stack memory seen by the dispatch block on its far side
// assumes one byte per req; read data is due in the cycle after the request
`timescale 1ns/100ps
`default_nettype none
module cid_stack_model (
  input wire logic pclk,
  input wire cid_pkg::cid_stack_t stack_bus,
  output logic [7:0] stack_rdata
);
  logic [7:0] mem [logic [15:0]];
  initial stack_rdata = 8'h00;
  always @(posedge pclk) begin
    if (stack_bus.req && stack_bus.we) begin
      mem[stack_bus.addr] = stack_bus.wdata;
    end
    // outside an answer the bus toggles, so a late or early sample cannot match by luck
    if (stack_bus.req && !stack_bus.we && mem.exists(stack_bus.addr)) begin
      stack_rdata <= mem[stack_bus.addr];
    end else begin
      stack_rdata <= ~stack_rdata;
    end
  end
endmodule : cid_stack_model
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the interrupt dispatch block
// assumes the stack model answers reads one cycle after the request
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [31:0] BOOT = 32'h0000_1c00;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, cpu_hold, pc_load;
  logic [7:0] src_event = 8'h00, src_level = 8'h00, stack_rdata, src_ack, ack;
  cid_pkg::cid_cpu_evt_t cpu_evt = '0;
  logic [12:0] cur_pc = 13'h0000, pc_load_value, reset_vector;
  logic app_lock = 1'b0, boot_lock = 1'b0, fuse = 1'b0;
  cid_pkg::cid_stack_t stack_bus;
  int err_count = 0, total_checks = 0, cyc = 0, n;

  always #2 pclk = ~pclk;

  cid_dispatch #(.LEVEL_MASK(8'h80)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_event(src_event), .src_level(src_level), .cpu_evt(cpu_evt), .cur_pc(cur_pc),
    .app_section_lock_bit(app_lock), .boot_section_lock_bit(boot_lock),
    .boot_reset_fuse(fuse), .cpu_hold(cpu_hold), .stack_bus(stack_bus),
    .stack_rdata(stack_rdata), .pc_load(pc_load), .pc_load_value(pc_load_value),
    .reset_vector(reset_vector), .src_ack(src_ack)
  );

  cid_stack_model partner (.pclk(pclk), .stack_bus(stack_bus), .stack_rdata(stack_rdata));

  task final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      final_report();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // request is held until pready is sampled high, then released
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // one completed instruction; ack is sampled inside its own cycle
  task instr(input logic cli, input logic sei, input logic return_from_handler_instr, input logic slp,
             input logic [12:0] pc);
    @(posedge pclk);
    cpu_evt <= {1'b1, cli, sei, return_from_handler_instr, slp};
    cur_pc <= pc;
    #1 ack = src_ack;
    @(posedge pclk);
    cpu_evt <= '0;
  endtask : instr

  task wait_load;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pc_load !== 1'b1 && n < 20);
  endtask : wait_load

  task fire(input logic [7:0] e);
    @(posedge pclk);
    src_event <= e;
    @(posedge pclk);
    src_event <= 8'h00;
  endtask : fire

  task end_test(input string s);
    $display("test %s done", s);
  endtask : end_test

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(cid_pkg::OFS_STATUS_FLAGS_REGISTER, 32'h0);
    rdchk(cid_pkg::OFS_SP, 32'h0);
    apb(1'b1, 8'h20, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1);
    rdchk(8'h20, 32'h0);
    chk({19'h0, reset_vector}, 32'h0);
    end_test("reset");
    apb(1'b1, cid_pkg::OFS_SP, 32'h100);
    apb(1'b1, cid_pkg::OFS_ENABLE, 32'h3);
    fire(8'h03);
    rdchk(cid_pkg::OFS_FLAGS, 32'h3);
    apb(1'b1, cid_pkg::OFS_STATUS_FLAGS_REGISTER, 32'ha5);
    instr(1'b1, 1'b0, 1'b0, 1'b0, 13'h0100);
    chk({24'h0, ack}, 32'h0);
    rdchk(cid_pkg::OFS_STATUS_FLAGS_REGISTER, 32'h25);
    apb(1'b1, cid_pkg::OFS_STATUS_FLAGS_REGISTER, 32'ha5);
    instr(1'b0, 1'b1, 1'b0, 1'b0, 13'h0100);
    chk({24'h0, ack}, 32'h0);
    app_lock <= 1'b1;
    instr(1'b0, 1'b0, 1'b0, 1'b0, 13'h0100);
    chk({24'h0, ack}, 32'h0);
    app_lock <= 1'b0;
    boot_lock <= 1'b1;
    instr(1'b0, 1'b0, 1'b0, 1'b0, 13'h1c10);
    chk({24'h0, ack}, 32'h0);
    boot_lock <= 1'b0;
    end_test("gating");
    instr(1'b0, 1'b0, 1'b0, 1'b0, 13'h0123);
    chk({24'h0, ack}, 32'h1);
    #1 chk({31'h0, cpu_hold}, 32'h1);
    wait_load;
    chk(n, 5);
    chk({31'h0, cpu_hold}, 32'h0);
    chk({19'h0, pc_load_value}, 32'h2);
    rdchk(cid_pkg::OFS_STATUS_FLAGS_REGISTER, 32'h25);
    rdchk(cid_pkg::OFS_SP, 32'hfe);
    rdchk(cid_pkg::OFS_FLAGS, 32'h2);
    rdchk(cid_pkg::OFS_STATE, 32'h700);
    apb(1'b1, cid_pkg::OFS_STATUS_FLAGS_REGISTER, 32'ha5);
    instr(1'b0, 1'b0, 1'b0, 1'b0, 13'h0003);
    chk({24'h0, ack}, 32'h2);
    wait_load;
    chk({19'h0, pc_load_value}, 32'h4);
    rdchk(cid_pkg::OFS_SP, 32'hfc);
    end_test("entry");
    instr(1'b0, 1'b0, 1'b1, 1'b0, 13'h0777);
    wait_load;
    chk(n, 5);
    chk({19'h0, pc_load_value}, 32'h3);
    rdchk(cid_pkg::OFS_STATUS_FLAGS_REGISTER, 32'ha5);
    rdchk(cid_pkg::OFS_SP, 32'hfe);
    instr(1'b0, 1'b0, 1'b1, 1'b0, 13'h0777);
    wait_load;
    chk({19'h0, pc_load_value}, 32'h123);
    rdchk(cid_pkg::OFS_SP, 32'h100);
    end_test("return");
    apb(1'b1, cid_pkg::OFS_CTRL, 32'h1);
    fire(8'h01);
    instr(1'b0, 1'b0, 1'b0, 1'b1, 13'h0200);
    chk({24'h0, ack}, 32'h1);
    wait_load;
    chk(n, 9);
    chk({19'h0, pc_load_value}, BOOT + 32'h2);
    apb(1'b1, cid_pkg::OFS_ENABLE, 32'h1);
    apb(1'b1, cid_pkg::OFS_STATUS_FLAGS_REGISTER, 32'h80);
    fire(8'h02);
    instr(1'b0, 1'b0, 1'b0, 1'b0, 13'h0200);
    chk({24'h0, ack}, 32'h0);
    apb(1'b1, cid_pkg::OFS_FLAGS, 32'h0);
    rdchk(cid_pkg::OFS_FLAGS, 32'h2);
    apb(1'b1, cid_pkg::OFS_FLAGS, 32'h2);
    rdchk(cid_pkg::OFS_FLAGS, 32'h0);
    src_level <= 8'h80;
    rdchk(cid_pkg::OFS_FLAGS, 32'h80);
    src_level <= 8'h00;
    rdchk(cid_pkg::OFS_FLAGS, 32'h0);
    end_test("misc");
    fuse <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({19'h0, reset_vector}, BOOT);
    rdchk(cid_pkg::OFS_STATUS_FLAGS_REGISTER, 32'h0);
    end_test("fuse");
    final_report();
  end
endmodule : testbench
`default_nettype wire
